// ### hdl/frb_reset_ctrl.sv
// Flash reset sequencer top
`default_nettype none
`include "frb_defs.svh"
module frb_reset_ctrl
  import frb_pkg::*;
#(
  parameter int PU_CYC    = (`FRB_T_PU_US * 1000 + `FRB_CLK_PERIOD_NS - 1) / `FRB_CLK_PERIOD_NS,
  parameter int RH_CYC    = (`FRB_T_RH_US * 1000 + `FRB_CLK_PERIOD_NS - 1) / `FRB_CLK_PERIOD_NS,
  parameter int CSR_CYC   = (`FRB_T_RESET_US * 1000 + `FRB_CLK_PERIOD_NS - 1) / `FRB_CLK_PERIOD_NS,
  parameter int SR_CYC    = (`FRB_T_SR_US * 1000 + `FRB_CLK_PERIOD_NS - 1) / `FRB_CLK_PERIOD_NS,
  parameter int RP_CYC    = (`FRB_T_RP_NS + `FRB_CLK_PERIOD_NS - 1) / `FRB_CLK_PERIOD_NS,
  parameter int DQ_W      = 4
)
(
  input  wire logic            clk_sys,          // System clock, 200 MHz
  input  wire logic            rst,              // Async reset, active high
  input  wire logic            spiClk,           // Serial link clock
  input  wire logic            csNIn,            // Chip select pin, active low
  input  wire logic            serialIoLine0In,  // Data line 0 pin
  input  wire logic            hwResetNIn,       // Hardware reset pin, active low
  input  wire logic            pwrGoodIn,        // Supply above threshold
  input  wire logic [DQ_W-1:0] coreDqOut,        // Core output data
  input  wire logic [DQ_W-1:0] coreDqOe,         // Core drive request per line
  output logic      [DQ_W-1:0] dqOut,            // Data pins, output value
  output logic      [DQ_W-1:0] dqOeN,            // Data pins, low while driving
  output logic                 readyBusyOutN,    // Low while resetting
  output frb_effects_s         effects,          // One-cycle reset effect pulses
  output frb_kind_e            resetKind,        // Kind of reset running
  output logic                 swArmed           // Software reset armed
);

  localparam int MAX_CYC = (PU_CYC > RH_CYC ? PU_CYC : RH_CYC) > (CSR_CYC > SR_CYC ? CSR_CYC : SR_CYC)
                         ? (PU_CYC > RH_CYC ? PU_CYC : RH_CYC) : (CSR_CYC > SR_CYC ? CSR_CYC : SR_CYC);
  localparam int CNT_W   = $clog2(MAX_CYC + 1) + 1;
  localparam int NPIN    = $bits(frb_pins_s);
  localparam frb_pins_s PIN_IDLE = '{csN: 1'b1, line0: 1'b0, clkLvl: 1'b0, hwRstN: 1'b1, pwrGood: 1'b0};

  if (PU_CYC < 1 || RH_CYC < 1 || CSR_CYC < 1 || SR_CYC < 1 || RP_CYC < 1 || DQ_W < 1 || RP_CYC > MAX_CYC)
  begin : g_bad_param
    $error("frb_reset_ctrl: counts and widths must be at least one");
  end

  function automatic logic [CNT_W-1:0] cyc(input int n);
    cyc = CNT_W'(n - 1);
  endfunction : cyc

  // Link side: capture first byte of each frame
  logic                     linkClr;
  logic [`FRB_BITCNT_W-1:0] bitCnt_reg;
  logic [`FRB_OPC_BITS-1:0] shift_reg;
  logic [`FRB_OPC_BITS-1:0] opcode_reg;
  logic                     opcTgl_reg;

  assign linkClr = rst | csNIn;

  always_ff @(posedge spiClk or posedge linkClr)
  begin
    if (linkClr)
    begin
      bitCnt_reg <= '0;
      shift_reg  <= '0;
    end
    else if (bitCnt_reg != `FRB_BITCNT_W'(`FRB_OPC_BITS))
    begin
      bitCnt_reg <= bitCnt_reg + `FRB_BITCNT_W'(1);
      shift_reg  <= {shift_reg[`FRB_OPC_BITS-2:0], serialIoLine0In};
    end
  end

  always_ff @(posedge spiClk or posedge rst)
  begin
    if (rst)
    begin
      opcode_reg <= '0;
      opcTgl_reg <= 1'b0;
    end
    else if (!csNIn && bitCnt_reg == `FRB_BITCNT_W'(`FRB_OPC_BITS - 1))
    begin
      opcode_reg <= {shift_reg[`FRB_OPC_BITS-2:0], serialIoLine0In};
      opcTgl_reg <= ~opcTgl_reg;
    end
  end

  // Pin and toggle synchronisers
  frb_pins_s             pinRaw;
  frb_pins_s             pinS;
  logic [NPIN-1:0]       pinSync1_reg;
  logic [NPIN-1:0]       pinSync2_reg;
  logic                  tglSync1_reg;
  logic                  tglSync2_reg;
  logic                  tglPrev_reg;

  assign pinRaw = '{csN: csNIn, line0: serialIoLine0In, clkLvl: spiClk, hwRstN: hwResetNIn, pwrGood: pwrGoodIn};
  assign pinS   = frb_pins_s'(pinSync2_reg);

  for (genvar i = 0; i < NPIN; i++)
  begin : g_sync
    always_ff @(posedge clk_sys or posedge rst)
    begin
      if (rst)
      begin
        pinSync1_reg[i] <= PIN_IDLE[i];
        pinSync2_reg[i] <= PIN_IDLE[i];
      end
      else
      begin
        pinSync1_reg[i] <= pinRaw[i];
        pinSync2_reg[i] <= pinSync1_reg[i];
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      tglSync1_reg <= 1'b0;
      tglSync2_reg <= 1'b0;
      tglPrev_reg  <= 1'b0;
    end
    else
    begin
      tglSync1_reg <= opcTgl_reg;
      tglSync2_reg <= tglSync1_reg;
      tglPrev_reg  <= tglSync2_reg;
    end
  end

  // Frame tracking in system domain
  frb_state_e               state_reg;
  logic                     csPrev_reg;
  logic                     csRise;
  logic                     opcSeen_reg;
  logic [`FRB_OPC_BITS-1:0] opcHeld_reg;
  logic                     csSigReq;
  logic                     hwLong;
  logic [CNT_W-1:0]         hwLowCnt_reg;
  logic                     swStart;
  logic                     hardBusy;

  assign csRise   = pinS.csN & ~csPrev_reg;
  assign hardBusy = state_reg == FRB_POR || state_reg == FRB_HW;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      csPrev_reg <= 1'b1;
    else
      csPrev_reg <= pinS.csN;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      opcSeen_reg <= 1'b0;
      opcHeld_reg <= '0;
    end
    else if (hardBusy)
      opcSeen_reg <= 1'b0;
    else if (tglSync2_reg != tglPrev_reg)
    begin
      opcSeen_reg <= 1'b1;
      opcHeld_reg <= opcode_reg;
    end
    else if (csRise)
      opcSeen_reg <= 1'b0;
  end

  // Arm on the arm frame, drop on any other frame carrying a full opcode byte
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      swArmed <= 1'b0;
    else if (state_reg != FRB_IDLE)
      swArmed <= 1'b0;
    else if (csRise && opcSeen_reg)
      swArmed <= opcHeld_reg == `FRB_ARM_OPCODE;
  end

  assign swStart = state_reg == FRB_IDLE && csRise && opcSeen_reg
                 && swArmed && opcHeld_reg == `FRB_EXEC_OPCODE;

  frb_cs_signal_det u_cs_det (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .enable   (!hardBusy),
    .csN      (pinS.csN),
    .line0    (pinS.line0),
    .clkLvl   (pinS.clkLvl),
    .resetReq (csSigReq)
  );

  // Hardware pin must stay low a minimum time
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      hwLowCnt_reg <= '0;
    else if (pinS.hwRstN)
      hwLowCnt_reg <= '0;
    else if (!hwLong)
      hwLowCnt_reg <= hwLowCnt_reg + CNT_W'(1);
  end

  assign hwLong = hwLowCnt_reg >= CNT_W'(RP_CYC);

  // Reset sequencer
  logic [CNT_W-1:0] cnt_reg;
  logic             csHwKind_reg;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_reg    <= FRB_POR;
      cnt_reg      <= '0;
      csHwKind_reg <= 1'b0;
    end
    else if (!pinS.pwrGood)
    begin
      state_reg <= FRB_POR;
      cnt_reg   <= '0;
    end
    else
    begin
      case (state_reg)
        FRB_POR:
        begin
          if (cnt_reg == cyc(PU_CYC))
            state_reg <= FRB_IDLE;
          else
            cnt_reg <= cnt_reg + CNT_W'(1);
        end
        FRB_HW:
        begin
          if (hwLong)
            cnt_reg <= '0;
          else if (cnt_reg == (csHwKind_reg ? cyc(CSR_CYC) : cyc(RH_CYC)))
            state_reg <= FRB_IDLE;
          else
            cnt_reg <= cnt_reg + CNT_W'(1);
        end
        FRB_SW:
        begin
          cnt_reg <= cnt_reg + CNT_W'(1);
          if (hwLong || csSigReq)
          begin
            state_reg    <= FRB_HW;
            csHwKind_reg <= !hwLong;
            cnt_reg      <= '0;
          end
          else if (cnt_reg == cyc(SR_CYC))
            state_reg <= FRB_IDLE;
        end
        FRB_IDLE:
        begin
          cnt_reg <= '0;
          if (hwLong || csSigReq)
          begin
            state_reg    <= FRB_HW;
            csHwKind_reg <= !hwLong;
          end
          else if (swStart)
            state_reg <= FRB_SW;
        end
        default:
        begin
          state_reg <= FRB_POR;
          cnt_reg   <= '0;
        end
      endcase
    end
  end

  // Effect pulses at the start of each reset's timed count
  logic enterHard;
  logic enterSw;

  assign enterHard = hardBusy && cnt_reg == '0 && (state_reg == FRB_POR ? pinS.pwrGood : !hwLong);
  assign enterSw   = state_reg == FRB_SW && cnt_reg == '0;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      effects <= '0;
    else
    begin
      effects.reloadNv      <= enterHard | enterSw;
      effects.clearVolatile <= enterHard;
      effects.clearStatus   <= enterHard | enterSw;
      effects.resetVolProt  <= enterHard | enterSw;
      effects.clearEcc      <= enterHard | enterSw;
      effects.reloadIoMode  <= enterHard;
      effects.abortErase    <= (enterHard && state_reg == FRB_HW) | enterSw;
      effects.abortProgram  <= (enterHard && state_reg == FRB_HW) | enterSw;
      effects.abortRead     <= enterHard && state_reg == FRB_HW;
    end
  end

  // Pins and status outputs
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      dqOut         <= '0;
      dqOeN         <= '1;
      readyBusyOutN <= 1'b0;
      resetKind     <= FRB_KIND_POR;
    end
    else
    begin
      readyBusyOutN <= state_reg == FRB_IDLE;
      if (hardBusy)
      begin
        dqOut <= '0;
        dqOeN <= '1;
      end
      else
      begin
        dqOut <= coreDqOut;
        dqOeN <= ~coreDqOe;
      end
      case (state_reg)
        FRB_POR:  resetKind <= FRB_KIND_POR;
        FRB_HW:   resetKind <= FRB_KIND_HW;
        FRB_SW:   resetKind <= FRB_KIND_SW;
        FRB_IDLE: resetKind <= FRB_KIND_NONE;
        default:  resetKind <= FRB_KIND_NONE;
      endcase
    end
  end

endmodule : frb_reset_ctrl
`default_nettype wire

// ### hdl/frb_defs.svh
// Constants for the flash reset sequencer
// Summary of operation
// - A software reset takes two transactions, reset-arm then reset-execute, and only that pair resets.
// - Every reset type reloads the volatile status and configuration registers from the non-volatile copies.
// - Power-on and hardware resets clear all volatile state; software reset clears status, volatile protection and ECC only.
// - During a power-on or hardware reset all input pins except the hardware reset and supply-good pins are ignored and no transaction is answered.
// - During a power-on or hardware reset every data output pin is released to high impedance.
// - A running erase is aborted by a hardware reset and by a software reset.
// - A software reset aborts a running program and a running erase, but not a running read.
// - A running read is aborted by a hardware reset.
// - Any transaction carrying a full opcode byte between reset-arm and reset-execute cancels the armed state.
// - The software reset starts only when chip select rises at the end of the execute transaction.
// - The ready/busy output is low for the whole of any reset and high once it has completed.
// - Four chip-select low pulses with a steady serial clock and alternating line 0 cause a reset.
`ifndef FRB_DEFS_SVH
`define FRB_DEFS_SVH

`define FRB_CLK_PERIOD_NS 5
`define FRB_T_PU_US       50
`define FRB_T_RH_US       10
`define FRB_T_RESET_US    10
`define FRB_T_SR_US       20
`define FRB_T_RP_NS       200
`define FRB_SYNC_STAGES   2
`define FRB_OPC_BITS      8
`define FRB_BITCNT_W      4
`define FRB_CSPULSES      3'h4
`define FRB_CSCNT_W       3
`define FRB_ARM_OPCODE    8'hA5
`define FRB_EXEC_OPCODE   8'h5A

`endif

// ### hdl/frb_pkg.sv
// Types for the flash reset sequencer
`default_nettype none
package frb_pkg;

  typedef enum logic [3:0] {
    FRB_IDLE = 4'b0001,
    FRB_POR  = 4'b0010,
    FRB_HW   = 4'b0100,
    FRB_SW   = 4'b1000
  } frb_state_e;

  typedef enum logic [1:0] {
    FRB_KIND_NONE = 2'h0,
    FRB_KIND_POR  = 2'h1,
    FRB_KIND_HW   = 2'h2,
    FRB_KIND_SW   = 2'h3
  } frb_kind_e;

  typedef struct packed {
    logic reloadNv;
    logic clearVolatile;
    logic clearStatus;
    logic resetVolProt;
    logic clearEcc;
    logic reloadIoMode;
    logic abortErase;
    logic abortProgram;
    logic abortRead;
  } frb_effects_s;

  typedef struct packed {
    logic csN;
    logic line0;
    logic clkLvl;
    logic hwRstN;
    logic pwrGood;
  } frb_pins_s;

endpackage : frb_pkg
`default_nettype wire

// ### hdl/frb_cs_signal_det.sv
// Chip-select signalling reset detector
`default_nettype none
`include "frb_defs.svh"
module frb_cs_signal_det
  import frb_pkg::*;
(
  input  wire logic clk_sys,   // System clock
  input  wire logic rst,       // Async reset
  input  wire logic enable,    // Detection allowed
  input  wire logic csN,       // Synced chip select
  input  wire logic line0,     // Synced data line 0
  input  wire logic clkLvl,    // Synced serial clock level
  output logic      resetReq   // One-cycle request
);

  logic                    csPrev_reg;
  logic                    clkPrev_reg;
  logic                    clkMoved_reg;
  logic [`FRB_CSCNT_W-1:0] pulseCnt_reg;
  logic                    expect_reg;
  logic                    csRise;

  assign csRise = csN & ~csPrev_reg;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      csPrev_reg  <= 1'b1;
      clkPrev_reg <= 1'b0;
    end
    else
    begin
      csPrev_reg  <= csN;
      clkPrev_reg <= clkLvl;
    end
  end

  // Any clock edge while selected spoils the pulse
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      clkMoved_reg <= 1'b0;
    else if (csN)
      clkMoved_reg <= 1'b0;
    else if (clkLvl != clkPrev_reg)
      clkMoved_reg <= 1'b1;
  end

  // Count pulses with alternating line 0, first one low
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      pulseCnt_reg <= '0;
      expect_reg   <= 1'b0;
      resetReq     <= 1'b0;
    end
    else
    begin
      resetReq <= 1'b0;
      if (!enable)
      begin
        pulseCnt_reg <= '0;
        expect_reg   <= 1'b0;
      end
      else if (csRise)
      begin
        if (!clkMoved_reg && line0 == expect_reg)
        begin
          if (pulseCnt_reg == `FRB_CSPULSES - 3'h1)
          begin
            resetReq     <= 1'b1;
            pulseCnt_reg <= '0;
            expect_reg   <= 1'b0;
          end
          else
          begin
            pulseCnt_reg <= pulseCnt_reg + 3'h1;
            expect_reg   <= ~expect_reg;
          end
        end
        else if (!clkMoved_reg && !line0)
        begin
          pulseCnt_reg <= 3'h1;
          expect_reg   <= 1'b1;
        end
        else
        begin
          pulseCnt_reg <= '0;
          expect_reg   <= 1'b0;
        end
      end
    end
  end

endmodule : frb_cs_signal_det
`default_nettype wire

// ### dv/frb_reset_ctrl_asserts.sv
// Port-level assertions for the flash reset sequencer
`default_nettype none
module frb_reset_ctrl_asserts
  import frb_pkg::*;
#(
  parameter int SR_CYC = 4000,
  parameter int DQ_W   = 4
)
(
  input wire logic            clk_sys,         // System clock
  input wire logic            rst,             // Async reset
  input wire logic            spiClk,          // Link clock
  input wire logic            csNIn,           // Chip select
  input wire logic            serialIoLine0In, // Line 0
  input wire logic            hwResetNIn,      // Reset pin
  input wire logic            pwrGoodIn,       // Supply good
  input wire logic [DQ_W-1:0] coreDqOut,       // Core data
  input wire logic [DQ_W-1:0] coreDqOe,        // Core enable
  input wire logic [DQ_W-1:0] dqOut,           // Pin data
  input wire logic [DQ_W-1:0] dqOeN,           // Pin enable
  input wire logic            readyBusyOutN,   // Busy flag
  input wire frb_effects_s    effects,         // Effect pulses
  input wire frb_kind_e       resetKind,       // Reset kind
  input wire logic            swArmed          // Armed flag
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  int   busyCnt_reg;
  logic swRun_reg;
  // Low cycles of the busy flag
  always_ff @(posedge clk_sys or posedge rst)
    if (rst) busyCnt_reg <= 0;
    else if (readyBusyOutN) busyCnt_reg <= 0;
    else busyCnt_reg <= busyCnt_reg + 1;
  always_ff @(posedge clk_sys or posedge rst)
    if (rst) swRun_reg <= 1'b0;
    else if (readyBusyOutN) swRun_reg <= 1'b0;
    else if (effects.abortProgram && resetKind == FRB_KIND_SW) swRun_reg <= 1'b1;

  sequence s_swEntry;
    effects.abortProgram && resetKind == FRB_KIND_SW;
  endsequence
  sequence s_hwHeld;
    (resetKind inside {FRB_KIND_POR, FRB_KIND_HW} && $stable(resetKind) && !readyBusyOutN) ##1 !readyBusyOutN;
  endsequence

  property p_swEffects;
    s_swEntry |-> effects == 9'h176;
  endproperty
  property p_swSeq;
    s_swEntry |-> !readyBusyOutN ##1 (effects == 9'h000 && !readyBusyOutN);
  endproperty
  property p_hwEffects;
    effects.abortRead |-> effects == 9'h1FF && resetKind == FRB_KIND_HW;
  endproperty
  property p_porEffects;
    effects.clearVolatile && !effects.abortErase |-> effects == 9'h1F8 && resetKind == FRB_KIND_POR;
  endproperty
  property p_tristate;
    s_hwHeld |-> $past(dqOeN) == '1 && $past(dqOut) == '0;
  endproperty
  property p_armClear;
    !readyBusyOutN && $past(!readyBusyOutN) |-> !swArmed;
  endproperty
  property p_effBusy;
    effects != 9'h000 |-> !readyBusyOutN;
  endproperty
  property p_swLen;
    $rose(readyBusyOutN) && swRun_reg |-> busyCnt_reg == SR_CYC;
  endproperty

  a_swEffects: assert property (p_swEffects)
    else $error("software reset effects wrong");
  a_swSeq: assert property (p_swSeq)
    else $error("software reset pulse or busy wrong");
  a_hwEffects: assert property (p_hwEffects)
    else $error("hardware reset effects wrong");
  a_porEffects: assert property (p_porEffects)
    else $error("power-on effects wrong");
  a_tristate: assert property (p_tristate)
    else $error("data pins driven during reset");
  a_armClear: assert property (p_armClear)
    else $error("armed during reset");
  a_effBusy: assert property (p_effBusy)
    else $error("effects while ready");
  a_swLen: assert property (p_swLen)
    else $error("software reset busy length wrong");
endmodule : frb_reset_ctrl_asserts

bind frb_reset_ctrl frb_reset_ctrl_asserts #(.SR_CYC(SR_CYC), .DQ_W(DQ_W)) frb_reset_ctrl_asserts_inst (
  .clk_sys(clk_sys), .rst(rst), .spiClk(spiClk), .csNIn(csNIn), .serialIoLine0In(serialIoLine0In),
  .hwResetNIn(hwResetNIn), .pwrGoodIn(pwrGoodIn), .coreDqOut(coreDqOut), .coreDqOe(coreDqOe),
  .dqOut(dqOut), .dqOeN(dqOeN), .readyBusyOutN(readyBusyOutN), .effects(effects),
  .resetKind(resetKind), .swArmed(swArmed));
`default_nettype wire

// ### dv/frb_host_model.sv
// Host link model sending opcode frames and signalling resets
`default_nettype none
module frb_host_model
  import frb_pkg::*;
(
  input  wire logic       go,     // Start a frame
  input  wire logic [7:0] opc,    // Opcode byte
  input  wire logic [3:0] nClk,   // Clocks in frame
  input  wire logic       csSig,  // Signalling reset
  output logic            spiClk, // Link clock
  output logic            csN,    // Chip select
  output logic            line0,  // Data line 0
  output logic            done    // Frame over
);
  timeunit 1ns;
  timeprecision 100ps;
  logic idleTog;
  initial
  begin
    spiClk = 1'b0;
    csN = 1'b1;
    line0 = 1'b0;
    done = 1'b0;
    idleTog = 1'b1;
  end
  // Released line keeps changing
  always #6 if (idleTog) line0 = ~line0;
  always @(posedge go)
  begin
    done = 1'b0;
    idleTog = 1'b0;
    if (csSig)
      for (int p = 0; p < 4; p++)
      begin
        line0 = p[0];
        #20 csN = 1'b0;
        #40 csN = 1'b1;
        #30;
      end
    else
    begin
      #10 csN = 1'b0;
      for (int i = 0; i < nClk; i++)
      begin
        line0 = opc[7 - i];
        #6 spiClk = 1'b1;
        #6 spiClk = 1'b0;
      end
      #6 csN = 1'b1;
      #30;
    end
    idleTog = 1'b1;
    done = 1'b1;
  end
endmodule : frb_host_model
`default_nettype wire

// ### dv/frb_reset_ctrl_tb.sv
// Self-checking bench for the flash reset sequencer
`default_nettype none
module frb_reset_ctrl_tb
  import frb_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [8:0] EFF_POR = 9'h1F8;
  localparam logic [8:0] EFF_HW  = 9'h1FF;
  localparam logic [8:0] EFF_SW  = 9'h176;
  logic         clk_sys = 1'b0;
  logic         rst = 1'b1;
  logic         hwResetNIn = 1'b1;
  logic         pwrGoodIn = 1'b0;
  logic [3:0]   coreDqOut = 4'h0;
  logic [3:0]   coreDqOe = 4'h0;
  logic         go = 1'b0;
  logic         csSig = 1'b0;
  logic [7:0]   opc = 8'h00;
  logic [3:0]   nClk = 4'h8;
  logic         spiClk, csNIn, line0, done, readyBusyOutN, swArmed;
  logic [3:0]   dqOut, dqOeN;
  frb_effects_s effects;
  frb_kind_e    resetKind;
  logic [10:0]  expQ[$];
  logic [7:0]   rnd = 8'h22;
  int           n_mismatch = 0;
  int           checks = 0;

  frb_reset_ctrl #(.PU_CYC(20), .RH_CYC(10), .CSR_CYC(10), .SR_CYC(10), .RP_CYC(3)) frb_reset_ctrl_inst (
    .clk_sys(clk_sys), .rst(rst), .spiClk(spiClk), .csNIn(csNIn), .serialIoLine0In(line0),
    .hwResetNIn(hwResetNIn), .pwrGoodIn(pwrGoodIn), .coreDqOut(coreDqOut), .coreDqOe(coreDqOe),
    .dqOut(dqOut), .dqOeN(dqOeN), .readyBusyOutN(readyBusyOutN), .effects(effects),
    .resetKind(resetKind), .swArmed(swArmed));
  frb_host_model frb_host_model_inst (.go(go), .opc(opc), .nClk(nClk), .csSig(csSig),
    .spiClk(spiClk), .csN(csNIn), .line0(line0), .done(done));

  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr

  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic wrap_up();
    $display("Mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up

  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : idle

  task automatic frame(input logic [7:0] o, input logic [3:0] n, input logic cs);
    int k;
    @(posedge clk_sys);
    opc <= o;
    nClk <= n;
    csSig <= cs;
    go <= 1'b1;
    k = 0;
    @(posedge clk_sys);
    while (done !== 1'b1 && k < 400)
    begin
      @(posedge clk_sys);
      k++;
    end
    if (k == 400) n_mismatch++;
    go <= 1'b0;
  endtask : frame

  task automatic waitIdle();
    int k;
    k = 0;
    while (readyBusyOutN !== 1'b1 && k < 500)
    begin
      @(negedge clk_sys);
      k++;
    end
    chk({10'h000, readyBusyOutN}, 11'h001);
  endtask : waitIdle

  always #2.5 clk_sys = ~clk_sys;

  always @(posedge clk_sys)
  begin
    rnd <= lfsr(rnd);
    coreDqOut <= rnd[3:0];
    coreDqOe <= rnd[7:4];
  end

  // Oldest note against each effect pulse
  always @(negedge clk_sys)
    if (!rst && effects !== 9'h000)
    begin
      if (expQ.size() == 0) chk({resetKind, effects}, 11'h000);
      else chk({resetKind, effects}, expQ.pop_front());
    end

  initial
  begin
    #100us;
    n_mismatch++;
    wrap_up();
  end

  initial
  begin
    expQ.push_back({FRB_KIND_POR, EFF_POR});
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (5) @(posedge clk_sys);
    pwrGoodIn <= 1'b1;
    waitIdle();
    frame(8'hA5, 4'h8, 1'b0);
    idle(4);
    chk({10'h000, swArmed}, 11'h001);
    frame(8'h00, 4'h4, 1'b0);
    expQ.push_back({FRB_KIND_SW, EFF_SW});
    frame(8'h5A, 4'h8, 1'b0);
    idle(2);
    chk({10'h000, readyBusyOutN}, 11'h000);
    waitIdle();
    frame(8'hA5, 4'h8, 1'b0);
    frame(rnd & 8'hF0, 4'h8, 1'b0);
    idle(4);
    chk({10'h000, swArmed}, 11'h000);
    frame(8'h5A, 4'h8, 1'b0);
    idle(6);
    chk({10'h000, readyBusyOutN}, 11'h001);
    @(posedge clk_sys) hwResetNIn <= 1'b0;
    frame(8'hA5, 4'h8, 1'b0);
    idle(1);
    chk({3'h0, dqOeN, dqOut}, 11'h0F0);
    chk({10'h000, swArmed}, 11'h000);
    chk({10'h000, readyBusyOutN}, 11'h000);
    expQ.push_back({FRB_KIND_HW, EFF_HW});
    @(posedge clk_sys) hwResetNIn <= 1'b1;
    waitIdle();
    @(posedge clk_sys) hwResetNIn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    hwResetNIn <= 1'b1;
    idle(10);
    chk({10'h000, readyBusyOutN}, 11'h001);
    expQ.push_back({FRB_KIND_HW, EFF_HW});
    frame(8'h00, 4'h0, 1'b1);
    idle(1);
    chk({7'h00, dqOeN}, 11'h00F);
    waitIdle();
    expQ.push_back({FRB_KIND_POR, EFF_POR});
    @(posedge clk_sys) pwrGoodIn <= 1'b0;
    repeat (5) @(posedge clk_sys);
    pwrGoodIn <= 1'b1;
    waitIdle();
    idle(5);
    chk(11'(expQ.size()), 11'h000);
    wrap_up();
  end
endmodule : frb_reset_ctrl_tb
`default_nettype wire
